// ### rtl/srsm_pkg.sv
// Constants, register map and carrier types of the receive slot mapper.
// Assumes one audio serial port with one word per slot and two receive channels.
package srsm_pkg;

   // Register addresses on the control port
   localparam logic [7:0] ADDR_PIN_SEL = 8'h27;
   localparam logic [7:0] ADDR_CH1 = 8'h28;
   localparam logic [7:0] ADDR_CH2 = 8'h29;

   // Reset values
   localparam logic [7:0] RST_PIN_SEL = 8'h00;
   localparam logic [7:0] RST_CH1 = 8'h20;
   localparam logic [7:0] RST_CH2 = 8'h21;

   // Field layout of a channel setup register
   localparam int EN_BIT = 5;
   localparam int SLOT_W = 5;
   localparam int RSV_LSB = 6;

   // Frame geometry
   localparam int NUM_CH = 2;
   localparam int SLOT_LOG2 = 5;
   localparam int WORD_W = 32;
   localparam int POS_W = 11;
   localparam logic [10:0] POS_START_I2S = 11'h7FF;
   localparam logic [10:0] POS_HOLD = 11'h400;
   localparam int FIFO_DEPTH = 32;

   // Serial frame formats
   typedef enum logic [1:0]
   {
      FMT_TDM = 2'b00,
      FMT_I2S = 2'b01,
      FMT_LEFT_JUSTIFIED = 2'b10
   } srsm_fmt_e;

   // Per-channel receive setup
   typedef struct packed
   {
      logic en;
      logic [SLOT_W-1:0] slot;
   } srsm_cfg_s;

   // One received sample tagged with its DAC channel
   typedef struct packed
   {
      logic [0:0] chan;
      logic [WORD_W-1:0] sample;
   } srsm_word_s;

endpackage

// ### rtl/srsm_fifo.sv
// Word FIFO with a registered output stage, valid and ready on both sides.
// Assumes DEPTH is a power of two; the output register adds one word of room.
`timescale 1ns/1ps
module srsm_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 32
) (
   input wire logic clk, // System clock
   input wire logic rst_b, // Async reset, active low
   input wire logic in_valid, // Write request
   output logic in_ready, // Room for a word
   input wire logic [WIDTH-1:0] in_data, // Write word
   output logic out_valid, // Word available
   input wire logic out_ready, // Consumer takes word
   output logic [WIDTH-1:0] out_data // Head word
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [CW-1:0] count, next_count;
   logic next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic push, load;

   // Handshakes and next pointer state
   always_comb
   begin
      in_ready = count < CW'(DEPTH);
      push = in_valid && in_ready;
      load = (count != '0) && (!out_valid || out_ready);
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = load ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + CW'(push) - CW'(load);
      next_out_valid = load ? 1'b1 : (out_ready ? 1'b0 : out_valid);
      next_out_data = load ? mem[rd_ptr] : out_data;
   end

   // Pointer and output registers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end
      else
      begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         out_valid <= next_out_valid;
         out_data <= next_out_data;
      end
   end

   // Storage write
   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wr_ptr] <= in_data;
      end
   end

   c_fifo_full: cover property (@(posedge clk) disable iff (!rst_b) count == CW'(DEPTH));

endmodule

// ### rtl/srsm_top.sv
// Receive slot mapper: picks each channel's slot out of serial frames for the DAC.
// Assumes the serial port pins are asynchronous and registers arrive on a byte port.
// What this block does
// - Bit 5 enables channel toward same DAC
// - Channel 1 enable reads one after reset
// - TDM slot field n selects slot n
// - Half formats: bit 4 picks right half
// - Channel 1 slot field resets to zero
// - Channel 2 at 0x29, resets 0x21
// - Channel 2 enable gates channel 2 data
// - Select bit picks primary or second pin
`timescale 1ns/1ps
module srsm_top #(
   parameter int FIFO_DEPTH = srsm_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk, // System clock, 100 MHz
   input wire logic rst_b, // Async reset, active low
   input wire logic [7:0] reg_addr, // Register address
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   input wire logic [7:0] reg_wdata, // Register write data
   output logic [7:0] reg_rdata, // Read data, valid after read
   input wire srsm_pkg::srsm_fmt_e link_format, // Frame format
   input wire logic bclk, // Serial bit clock pin
   input wire logic fsync, // Frame sync pin
   input wire logic din, // Primary data pin
   input wire logic serial_input_pin_b, // Secondary data pin
   output logic dac_valid, // Sample ready for DAC
   input wire logic dac_ready, // DAC takes sample
   output srsm_pkg::srsm_word_s dac_word // Sample and channel
);
   srsm_pkg::srsm_cfg_s cfg [srsm_pkg::NUM_CH];
   srsm_pkg::srsm_cfg_s next_cfg [srsm_pkg::NUM_CH];
   logic [srsm_pkg::NUM_CH-1:0] pin_sel, next_pin_sel;
   logic [7:0] next_rdata;
   logic [2:0] bclk_q;
   logic [1:0] fsync_q, din_q, dinb_q;
   logic samp, fs, frame_edge;
   logic fs_prev, next_fs_prev, half, next_half;
   logic [srsm_pkg::POS_W-1:0] pos, next_pos;
   logic [srsm_pkg::NUM_CH-1:0] pend_v, shift_v, grant, bit_v;
   logic [srsm_pkg::WORD_W-1:0] hold_v [srsm_pkg::NUM_CH];
   logic fifo_in_ready;
   srsm_pkg::srsm_word_s fifo_in_data;
   logic [srsm_pkg::NUM_CH-1:0] wrote, next_wrote;

   // Register writes and registered read data
   always_comb
   begin
      next_cfg = cfg;
      next_pin_sel = pin_sel;
      next_rdata = reg_rdata;
      next_wrote = wrote;
      if (reg_wr && reg_addr == srsm_pkg::ADDR_PIN_SEL)
      begin
         next_pin_sel = reg_wdata[srsm_pkg::NUM_CH-1:0];
      end
      for (int k = 0; k < srsm_pkg::NUM_CH; k++)
      begin
         if (reg_wr && reg_addr == srsm_pkg::ADDR_CH1 + 8'(k))
         begin
            next_cfg[k].en = reg_wdata[srsm_pkg::EN_BIT];
            next_cfg[k].slot = reg_wdata[srsm_pkg::SLOT_W-1:0];
            next_wrote[k] = 1'b1;
         end
      end
      if (reg_rd)
      begin
         next_rdata = '0; // Unmapped and reserved bits read zero
         if (reg_addr == srsm_pkg::ADDR_PIN_SEL)
         begin
            next_rdata[srsm_pkg::NUM_CH-1:0] = pin_sel;
         end
         for (int k = 0; k < srsm_pkg::NUM_CH; k++)
         begin
            if (reg_addr == srsm_pkg::ADDR_CH1 + 8'(k))
            begin
               next_rdata[srsm_pkg::EN_BIT] = cfg[k].en;
               next_rdata[srsm_pkg::SLOT_W-1:0] = cfg[k].slot;
            end
         end
      end
   end

   // Register state
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg[0].en <= srsm_pkg::RST_CH1[srsm_pkg::EN_BIT];
         cfg[0].slot <= srsm_pkg::RST_CH1[srsm_pkg::SLOT_W-1:0];
         cfg[1].en <= srsm_pkg::RST_CH2[srsm_pkg::EN_BIT];
         cfg[1].slot <= srsm_pkg::RST_CH2[srsm_pkg::SLOT_W-1:0];
         pin_sel <= srsm_pkg::RST_PIN_SEL[srsm_pkg::NUM_CH-1:0];
         reg_rdata <= '0;
         wrote <= '0;
      end
      else
      begin
         cfg <= next_cfg;
         pin_sel <= next_pin_sel;
         reg_rdata <= next_rdata;
         wrote <= next_wrote;
      end
   end

   // Pin synchronisers; bit clock keeps a third stage for edge finding
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bclk_q <= '0;
         fsync_q <= '0;
         din_q <= '0;
         dinb_q <= '0;
      end
      else
      begin
         bclk_q <= {bclk_q[1:0], bclk};
         fsync_q <= {fsync_q[0], fsync};
         din_q <= {din_q[0], din};
         dinb_q <= {dinb_q[0], serial_input_pin_b};
      end
   end

   // Bit position within the frame, taken on each bit clock rise
   always_comb
   begin
      samp = bclk_q[1] && !bclk_q[2];
      fs = fsync_q[1];
      frame_edge = (link_format == srsm_pkg::FMT_TDM) ? (fs && !fs_prev) : (fs != fs_prev);
      next_fs_prev = fs_prev;
      next_half = half;
      next_pos = pos;
      if (samp)
      begin
         next_fs_prev = fs;
         if (frame_edge)
         begin
            // I2S data trails the sync edge by one bit
            next_pos = (link_format == srsm_pkg::FMT_I2S) ? srsm_pkg::POS_START_I2S : '0;
            next_half = (link_format == srsm_pkg::FMT_LEFT_JUSTIFIED) ? !fs : fs;
         end
         else if (pos == srsm_pkg::POS_START_I2S)
         begin
            next_pos = '0;
         end
         else if (!pos[srsm_pkg::POS_W-1])
         begin
            next_pos = pos + 1'b1;
         end
      end
   end

   // Frame position registers
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fs_prev <= 1'b0;
         half <= 1'b0;
         pos <= srsm_pkg::POS_HOLD;
      end
      else
      begin
         fs_prev <= next_fs_prev;
         half <= next_half;
         pos <= next_pos;
      end
   end

   // Per-channel slot capture
   for (genvar i = 0; i < srsm_pkg::NUM_CH; i++)
   begin : g_ch
      logic [srsm_pkg::WORD_W-1:0] sr, next_sr, hold, next_hold;
      logic pend, next_pend, match, last;

      always_comb
      begin
         if (link_format == srsm_pkg::FMT_TDM)
         begin
            match = next_pos[srsm_pkg::SLOT_LOG2 +: srsm_pkg::SLOT_W] == cfg[i].slot;
         end
         else
         begin
            match = !next_pos[srsm_pkg::SLOT_LOG2 + 4] &&
                    ({next_half, next_pos[srsm_pkg::SLOT_LOG2 +: 4]} == cfg[i].slot);
         end
         match = match && !next_pos[srsm_pkg::POS_W-1];
         last = &next_pos[srsm_pkg::SLOT_LOG2-1:0];
         shift_v[i] = samp && cfg[i].en && match;
         bit_v[i] = pin_sel[i] ? dinb_q[1] : din_q[1];
         next_sr = shift_v[i] ? {sr[srsm_pkg::WORD_W-2:0], bit_v[i]} : sr;
         next_hold = hold;
         next_pend = pend && !grant[i];
         if (shift_v[i] && last)
         begin
            next_hold = {sr[srsm_pkg::WORD_W-2:0], bit_v[i]};
            next_pend = 1'b1; // New word wins over the grant
         end
      end

      always_ff @(posedge ref_clk or negedge rst_b)
      begin
         if (!rst_b)
         begin
            sr <= '0;
            hold <= '0;
            pend <= 1'b0;
         end
         else
         begin
            sr <= next_sr;
            hold <= next_hold;
            pend <= next_pend;
         end
      end

      assign pend_v[i] = pend;
      assign hold_v[i] = hold;
   end

   // Channel 1 first when both words are waiting
   always_comb
   begin
      grant[0] = pend_v[0] && fifo_in_ready;
      grant[1] = pend_v[1] && !pend_v[0] && fifo_in_ready;
      fifo_in_data.chan = pend_v[0] ? 1'b0 : 1'b1;
      fifo_in_data.sample = pend_v[0] ? hold_v[0] : hold_v[1];
   end

   // Sample buffer toward the DAC path
   srsm_fifo #(
      .WIDTH($bits(srsm_pkg::srsm_word_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst_b(rst_b),
      .in_valid(|pend_v),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(dac_valid),
      .out_ready(dac_ready),
      .out_data(dac_word)
   );

   // Checks on register defaults, slot choice and hand-off
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);

   a_ch1_reset_enable: assert property (reg_rd && reg_addr == srsm_pkg::ADDR_CH1 && !wrote[0] |=> reg_rdata[5])
      else $error("channel 1 enable not set after reset");
   a_ch1_reset_slot: assert property (reg_rd && reg_addr == srsm_pkg::ADDR_CH1 && !wrote[0] |=> reg_rdata[4:0] == 5'h00)
      else $error("channel 1 slot not zero after reset");
   a_ch2_reset_value: assert property (reg_rd && reg_addr == srsm_pkg::ADDR_CH2 && !wrote[1] |=> reg_rdata == 8'h21)
      else $error("channel 2 reset value wrong");
   a_reserved_read_zero: assert property (reg_rd && reg_addr[7:1] == 7'h14 |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved bits read nonzero");
   a_ch1_needs_enable: assert property ($rose(pend_v[0]) |-> $past(cfg[0].en))
      else $error("disabled channel 1 produced a word");
   a_ch2_needs_enable: assert property ($rose(pend_v[1]) |-> $past(cfg[1].en))
      else $error("disabled channel 2 produced a word");
   a_tdm_slot_match: assert property (shift_v[0] && link_format == srsm_pkg::FMT_TDM |-> next_pos[9:5] == cfg[0].slot)
      else $error("channel 1 captured outside its TDM slot");
   a_half_slot_match: assert property (shift_v[1] && link_format != srsm_pkg::FMT_TDM
                                       |-> next_half == cfg[1].slot[4] && !next_pos[9])
      else $error("channel 2 captured in wrong half");
   a_pin_select_bit: assert property (shift_v[0] |=> g_ch[0].sr[0] == $past(pin_sel[0] ? dinb_q[1] : din_q[1]))
      else $error("channel 1 shifted wrong pin");
   a_word_handoff: assert property (pend_v[0] && fifo_in_ready |=> !pend_v[0] ##1 !pend_v[0])
      else $error("channel 1 word not handed to buffer");
   a_dac_word_hold: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_word))
      else $error("DAC word dropped while stalled");

   c_ch1_word_tdm: cover property (grant[0] && link_format == srsm_pkg::FMT_TDM);
   c_ch2_word_left: cover property (grant[1] && link_format == srsm_pkg::FMT_LEFT_JUSTIFIED);
   c_buffer_stall: cover property (|pend_v && !fifo_in_ready);
   c_dac_take_ch2: cover property (dac_valid && dac_ready && dac_word.chan == 1'b1);

endmodule

// ### tb/srsm_frame_src.sv
// Serial frame source standing in for the host audio controller.
// Assumes the bench hands over the slot word tables with each frame.
`timescale 1ns/1ps
module srsm_frame_src (
   output logic bclk, // Bit clock, still between frames
   output logic fsync, // Frame sync
   output logic din, // Primary data pin
   output logic pin_b // Secondary data pin
);
   // Idle levels at time zero
   initial
   begin
      bclk = 1'b0;
      fsync = 1'b0;
      din = 1'b0;
      pin_b = 1'b0;
   end

   // One frame of h slots (per half in I2S and left-justified), MSB first, data moves while bclk low
   task automatic send(input srsm_pkg::srsm_fmt_e f, input int h, input logic [31:0] a [32],
      input logic [31:0] b [32]);
      int n;
      int d;
      int i;
      bit tdm;
      tdm = (f == srsm_pkg::FMT_TDM);
      n = tdm ? h * 32 : h * 64;
      if (f == srsm_pkg::FMT_I2S)
         n = n + 2;
      for (int c = 0; c < n; c++)
      begin
         d = (f == srsm_pkg::FMT_I2S) ? c - 2 : c;
         if (tdm)
            fsync = (c == 0);
         else if (f == srsm_pkg::FMT_LEFT_JUSTIFIED)
            fsync = (c < h * 32);
         else
            fsync = (c == 0) || (c > h * 32);
         i = (tdm || d < h * 32) ? d / 32 : 16 + d / 32 - h;
         if (d >= 0)
         begin
            din = a[i][31 - d % 32];
            pin_b = b[i][31 - d % 32];
         end
         #62.5 bclk = 1'b1;
         #62.5 bclk = 1'b0;
      end
      // Released lines show the inverse of their last bit
      din = ~din;
      pin_b = ~pin_b;
   endtask
endmodule

// ### tb/srsm_top_tb_top.sv
// Bench for the receive slot mapper: register port, frames in each format, DAC stream.
// Assumes the frame source model drives the serial pins with a 125 ns bit clock.
`timescale 1ns/1ps
module srsm_top_tb_top;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   srsm_pkg::srsm_fmt_e link_format = srsm_pkg::FMT_TDM;
   logic bclk;
   logic fsync;
   logic din;
   logic pin_b;
   logic dac_valid;
   logic dac_ready = 1'b0;
   srsm_pkg::srsm_word_s dac_word;
   logic [7:0] cfg [3] = '{8'h00, 8'h20, 8'h21};
   logic [31:0] wa [32];
   logic [31:0] wb [32];
   logic [7:0] rq [$];
   srsm_pkg::srsm_word_s wq [$];
   logic rd_d = 1'b0;
   bit stall = 1'b0;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int seed = 69620;

   srsm_top #(.FIFO_DEPTH(4)) srsm_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .link_format(link_format), .bclk(bclk), .fsync(fsync), .din(din), .serial_input_pin_b(pin_b),
      .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_word(dac_word));
   srsm_frame_src srsm_frame_src_i (.bclk(bclk), .fsync(fsync), .din(din), .pin_b(pin_b));

   // Clock, 10 ns period
   always #5 ref_clk = ~ref_clk;

   task automatic report_and_stop;
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Byte compare
   task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask

   // DAC word against the oldest note
   task automatic cmpw(input srsm_pkg::srsm_word_s g);
      srsm_pkg::srsm_word_s e;
      e = 'x;
      if (wq.size() != 0)
         e = wq.pop_front();
      cmp_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("ERROR dac_word expected %h seen %h", e, g);
      end
   endtask

   // Register write, shadow keeps only the writable bits
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      cfg[a - 8'h27] = d & ((a == 8'h27) ? 8'h03 : 8'h3F);
   endtask

   // Register read, expected byte noted
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      rq.push_back(e);
      @(negedge ref_clk);
      reg_rd = 1'b0;
   endtask

   // Notes the expected words of one frame, then sends it
   task automatic frame(input srsm_pkg::srsm_fmt_e f, input int h);
      int x;
      bit tdm;
      tdm = (f == srsm_pkg::FMT_TDM);
      link_format = f;
      for (int k = 0; k < 32; k++)
      begin
         wa[k] = $random(seed);
         wb[k] = $random(seed);
      end
      for (int s = 0; s < (tdm ? h : 2 * h); s++)
      begin
         x = (tdm || s < h) ? s : 16 + s - h;
         for (int c = 0; c < 2; c++)
            if (cfg[c + 1][5] && cfg[c + 1][4:0] == x)
               wq.push_back({1'(c), cfg[0][c] ? wb[x] : wa[x]});
      end
      srsm_frame_src_i.send(f, h, wa, wb);
   endtask

   // Lets the DAC side empty the buffer
   task automatic drain;
      stall = 1'b0;
      for (int i = 0; i < 300 && wq.size() != 0; i++)
         @(negedge ref_clk);
      cmp8("words left", 8'h00, 8'(wq.size()));
   endtask

   // Random consumer stalls, held off while stall is set
   always @(negedge ref_clk)
      dac_ready <= !stall && ($random(seed) % 4 != 0);

   // Results against the oldest notes, then the cycle ceiling
   always @(posedge ref_clk)
   begin
      cyc++;
      if (rd_d === 1'b1)
         cmp8("reg_rdata", rq.pop_front(), reg_rdata);
      rd_d <= reg_rd;
      if (dac_valid === 1'b1 && dac_ready === 1'b1)
         cmpw(dac_word);
      if (cyc == 40000)
      begin
         bad_count++;
         report_and_stop;
      end
   end

   // Main sequence
   initial
   begin
      repeat (16) @(negedge ref_clk);
      rst_b = 1'b1;
      rd(8'h27, 8'h00);
      rd(8'h28, 8'h20);
      rd(8'h29, 8'h21);
      rd(8'h30, 8'h00);
      frame(srsm_pkg::FMT_TDM, 4);
      drain;
      wr(8'h28, 8'h3F);
      wr(8'h29, 8'h05);
      rd(8'h28, 8'h3F);
      rd(8'h29, 8'h05);
      frame(srsm_pkg::FMT_TDM, 32);
      drain;
      wr(8'h27, 8'h01);
      wr(8'h28, 8'h22);
      wr(8'h29, 8'h22);
      frame(srsm_pkg::FMT_TDM, 4);
      drain;
      wr(8'h27, 8'h02);
      wr(8'h28, 8'h20);
      wr(8'h29, 8'h21);
      stall = 1'b1;
      repeat (3) frame(srsm_pkg::FMT_TDM, 2);
      drain;
      wr(8'h28, 8'h01);
      frame(srsm_pkg::FMT_TDM, 2);
      drain;
      wr(8'h28, 8'h30);
      frame(srsm_pkg::FMT_LEFT_JUSTIFIED, 2);
      drain;
      wr(8'h28, 8'h31);
      wr(8'h29, 8'h20);
      frame(srsm_pkg::FMT_I2S, 2);
      drain;
      report_and_stop;
   end
endmodule
